// ---- hdl/dpb_defines.svh ----
// constants for the ddr psram burst transaction block
// assumes inclusion by bare name from the block's design files
`ifndef DPB_DEFINES_SVH
`define DPB_DEFINES_SVH

// command-address field positions
`define DPB_CA_RW_BIT 47
`define DPB_CA_SPACE_BIT 46
`define DPB_CA_BURST_BIT 45
`define DPB_CA_ROW_HI 35
`define DPB_CA_ROW_LO 16
`define DPB_CA_COL_HI 2
`define DPB_CA_REG_HI 7
// index of the last of the six command-address bytes
`define DPB_CA_LAST_BYTE 3'h5
// word address width and write buffer shape
`define DPB_ADDR_W 23
`define DPB_WR_W 41
`define DPB_FIFO_DEPTH 4
// smallest wrap length in words
`define DPB_WRAP_MIN_WORDS 32'd8
// reset values
`define DPB_BYTE_RST 8'h00
`define DPB_WORD_RST 16'h0000

`endif

// ---- hdl/dpb_pkg.sv ----
// types for the ddr psram burst transaction block
// assumes the defines header is compiled alongside
package dpb_pkg;

	typedef enum logic [2:0] {
		DPB_IDLE = 3'b000,
		DPB_CA = 3'b001,
		DPB_LAT = 3'b010,
		DPB_RDATA = 3'b011,
		DPB_WDATA = 3'b100,
		DPB_REGW = 3'b101,
		DPB_DONE = 3'b110
	} dpb_state_e;

	typedef logic [22:0] dpb_addr_t;

endpackage : dpb_pkg

// ---- hdl/dpb_fifo.sv ----
// small valid/ready fifo for buffered array writes
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module dpb_fifo #(
	parameter int WIDTH = 41,
	parameter int DEPTH = 4
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
	logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
	logic [AW:0] count_ff, nxt_count;
	logic push, pop;

	assign in_ready = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data = mem_ff[rd_ptr_ff];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count = count_ff;
		if (push) begin
			nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
		end
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
		end
	end

	// storage needs no reset; words are only read once valid
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

endmodule : dpb_fifo

// ---- hdl/dpb_burst.sv ----
// ddr psram transaction logic: command-address, latency, bursts
// assumes link pins are asynchronous to ref_clk and far slower than it
// Functional notes
// - command-address takes three clocks, six bytes, forty-eight bits.
// - command bit 47 high means read, low means write.
// - command bit 46 low selects array, high selects register space.
// - command bit 45 picks wrapped or linear burst per transaction.
// - array access may start from bits 35..16; low bits pick word.
// - fixed latency only; strobe high during command phase, latency doubled.
// - after latency, read data and strobe toggle together, edge aligned.
// - upper byte on strobe high half, lower byte on low half.
// - reads continue while clocked; strobe held low to insert latency.
// - wrapped reads wrap in burst length; linear reads run sequentially.
// - master may end anytime by raising chip select with clock idle.
// - write bytes centre aligned; first on rising, second on falling.
// - device drives strobe during command phase, then releases it.
// - strobe high masks a written byte; low stores it.
// - no latency inserted during write data; master owns strobe.
// - wrapped writes wrap; hybrid wraps once then runs linear.
// - linear writes run sequentially and roll over past the top.
// - zero-latency writes are full words; device releases the strobe.
`timescale 1ns/1ps
`include "dpb_defines.svh"
module dpb_burst (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic link_clk,
	input wire logic chip_sel_b,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out,
	output logic dq_oe,
	input wire logic strobe_mask_in,
	output logic strobe_mask_out,
	output logic strobe_mask_oe,
	input wire logic [3:0] latency_count,
	input wire logic [1:0] wrap_code,
	input wire logic hybrid_wrap,
	output logic mem_rd_req,
	output logic [22:0] mem_rd_addr,
	input wire logic mem_rd_valid,
	input wire logic [15:0] mem_rd_data,
	output logic mem_wr_valid,
	input wire logic mem_wr_ready,
	output logic [22:0] mem_wr_addr,
	output logic [15:0] mem_wr_data,
	output logic [1:0] mem_wr_be,
	output logic [7:0] reg_addr,
	input wire logic [15:0] reg_rd_data,
	output logic reg_wr,
	output logic [15:0] reg_wr_data,
	output logic wr_overrun
);
	// next word address for wrapped, hybrid and linear bursts
	function automatic logic [23:0] adv_addr(
		input dpb_pkg::dpb_addr_t addr,
		input dpb_pkg::dpb_addr_t start,
		input logic linear,
		input logic hybrid,
		input logic [1:0] code
	);
		dpb_pkg::dpb_addr_t wmask;
		dpb_pkg::dpb_addr_t inc;
		dpb_pkg::dpb_addr_t wrapped;
		wmask = dpb_pkg::dpb_addr_t'((`DPB_WRAP_MIN_WORDS << code) - 32'd1);
		inc = addr + 1'b1;
		wrapped = (addr & ~wmask) | (inc & wmask);
		if (linear) begin
			adv_addr = {1'b1, inc};
		end else if (hybrid && ((wrapped & wmask) == (start & wmask))) begin
			adv_addr = {1'b1, (addr & ~wmask) + wmask + 1'b1};
		end else begin
			adv_addr = {1'b0, wrapped};
		end
	endfunction : adv_addr

	logic [10:0] sync1_ff, sync2_ff;
	logic ck_d_ff;
	logic ck_s, cs_s, sm_s, rise, fall;
	logic [7:0] dq_s;

	assign ck_s = sync2_ff[10];
	assign cs_s = sync2_ff[9];
	assign sm_s = sync2_ff[8];
	assign dq_s = sync2_ff[7:0];
	assign rise = ck_s & ~ck_d_ff;
	assign fall = ~ck_s & ck_d_ff;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_ff <= 11'h200;
			sync2_ff <= 11'h200;
			ck_d_ff <= 1'b0;
		end else begin
			sync1_ff <= {link_clk, chip_sel_b, strobe_mask_in, dq_in};
			sync2_ff <= sync1_ff;
			ck_d_ff <= ck_s;
		end
	end

	dpb_pkg::dpb_state_e state_ff, nxt_state;
	logic [2:0] byte_cnt_ff, nxt_byte_cnt;
	logic [47:0] ca_ff, nxt_ca;
	logic [47:0] ca_full;
	logic [4:0] lat_cnt_ff, nxt_lat_cnt, lat_total;
	dpb_pkg::dpb_addr_t addr_ff, nxt_addr, start_ff, nxt_start;
	logic linear_ff, nxt_linear, is_rd_ff, nxt_is_rd, is_reg_ff, nxt_is_reg;
	logic phase_ff, nxt_phase, mask_hi_ff, nxt_mask_hi;
	logic [7:0] hi_ff, nxt_hi;
	logic [15:0] rd_word_ff, nxt_rd_word;
	logic rd_have_ff, nxt_rd_have;
	logic [7:0] dq_out_ff, nxt_dq_out;
	logic dq_oe_ff, nxt_dq_oe, sm_out_ff, nxt_sm_out, sm_oe_ff, nxt_sm_oe;
	logic rd_req_ff, nxt_rd_req, reg_wr_ff, nxt_reg_wr;
	logic [15:0] reg_wr_data_ff, nxt_reg_wr_data;
	logic [7:0] reg_addr_ff, nxt_reg_addr;
	logic overrun_ff, nxt_overrun;
	logic [23:0] step;
	logic push, fifo_in_ready;
	logic [40:0] push_data;

	assign ca_full = {ca_ff[39:0], dq_s};
	assign lat_total = {latency_count, 1'b0};
	assign step = adv_addr(addr_ff, start_ff, linear_ff, hybrid_wrap,
		wrap_code);
	assign push = (state_ff == dpb_pkg::DPB_WDATA) && fall && phase_ff
		&& !cs_s;
	// strobe high masks a byte, so enables are its inverse
	assign push_data = {addr_ff, hi_ff, dq_s, ~mask_hi_ff, ~sm_s};

	always_comb begin
		nxt_state = state_ff;
		nxt_byte_cnt = byte_cnt_ff;
		nxt_ca = ca_ff;
		nxt_lat_cnt = lat_cnt_ff;
		nxt_addr = addr_ff;
		nxt_start = start_ff;
		nxt_linear = linear_ff;
		nxt_is_rd = is_rd_ff;
		nxt_is_reg = is_reg_ff;
		nxt_phase = phase_ff;
		nxt_mask_hi = mask_hi_ff;
		nxt_hi = hi_ff;
		nxt_rd_word = rd_word_ff;
		nxt_rd_have = rd_have_ff;
		nxt_dq_out = dq_out_ff;
		nxt_dq_oe = dq_oe_ff;
		nxt_sm_out = sm_out_ff;
		nxt_sm_oe = sm_oe_ff;
		nxt_rd_req = 1'b0;
		nxt_reg_wr = 1'b0;
		nxt_reg_wr_data = reg_wr_data_ff;
		nxt_reg_addr = reg_addr_ff;
		nxt_overrun = overrun_ff;
		if (cs_s) begin
			// deselect ends any transfer and frees the pins
			nxt_state = dpb_pkg::DPB_IDLE;
			nxt_dq_oe = 1'b0;
			nxt_sm_oe = 1'b0;
			nxt_rd_have = 1'b0;
		end else begin
			unique case (state_ff)
				dpb_pkg::DPB_IDLE: begin
					// strobe high flags the fixed extra latency
					nxt_state = dpb_pkg::DPB_CA;
					nxt_sm_oe = 1'b1;
					nxt_sm_out = 1'b1;
					nxt_byte_cnt = 3'h0;
					nxt_overrun = 1'b0;
				end
				dpb_pkg::DPB_CA: begin
					if (rise || fall) begin
						nxt_ca = ca_full;
						nxt_byte_cnt = byte_cnt_ff + 3'h1;
						if (byte_cnt_ff == `DPB_CA_LAST_BYTE) begin
							nxt_is_rd = ca_full[`DPB_CA_RW_BIT];
							nxt_is_reg = ca_full[`DPB_CA_SPACE_BIT];
							nxt_linear = ca_full[`DPB_CA_BURST_BIT];
							// row and upper column, then word within row
							nxt_addr = {ca_full[`DPB_CA_ROW_HI:`DPB_CA_ROW_LO],
								ca_full[`DPB_CA_COL_HI:0]};
							nxt_start = nxt_addr;
							nxt_reg_addr = ca_full[`DPB_CA_REG_HI:0];
							nxt_lat_cnt = 5'h00;
							nxt_phase = 1'b0;
							nxt_sm_oe = 1'b0;
							nxt_sm_out = 1'b0;
							if (ca_full[`DPB_CA_RW_BIT]) begin
								// read keeps strobe low through latency
								nxt_sm_oe = 1'b1;
								if (ca_full[`DPB_CA_SPACE_BIT]) begin
									nxt_rd_word = reg_rd_data;
									nxt_rd_have = 1'b1;
								end else begin
									nxt_rd_req = 1'b1;
								end
							end
							if (!ca_full[`DPB_CA_RW_BIT]
								&& ca_full[`DPB_CA_SPACE_BIT]) begin
								nxt_state = dpb_pkg::DPB_REGW;
							end else if (lat_total == 5'h00) begin
								nxt_state = ca_full[`DPB_CA_RW_BIT] ?
									dpb_pkg::DPB_RDATA : dpb_pkg::DPB_WDATA;
							end else begin
								nxt_state = dpb_pkg::DPB_LAT;
							end
						end
					end
				end
				dpb_pkg::DPB_LAT: begin
					if (rise) begin
						nxt_lat_cnt = lat_cnt_ff + 5'h01;
						if (lat_cnt_ff + 5'h01 == lat_total) begin
							nxt_state = is_rd_ff ?
								dpb_pkg::DPB_RDATA : dpb_pkg::DPB_WDATA;
						end
					end
				end
				dpb_pkg::DPB_RDATA: begin
					if (rise) begin
						if (rd_have_ff) begin
							nxt_dq_out = rd_word_ff[15:8];
							nxt_dq_oe = 1'b1;
							nxt_sm_out = 1'b1;
							nxt_phase = 1'b1;
						end else begin
							nxt_sm_out = 1'b0;
						end
					end else if (fall && phase_ff) begin
						nxt_dq_out = rd_word_ff[7:0];
						nxt_sm_out = 1'b0;
						nxt_phase = 1'b0;
						nxt_addr = step[22:0];
						nxt_linear = linear_ff | step[23];
						if (!is_reg_ff) begin
							nxt_rd_have = 1'b0;
							nxt_rd_req = 1'b1;
						end
					end
				end
				dpb_pkg::DPB_WDATA: begin
					// master owns the strobe; no stalls are possible
					if (rise) begin
						nxt_hi = dq_s;
						nxt_mask_hi = sm_s;
						nxt_phase = 1'b1;
					end else if (push) begin
						nxt_phase = 1'b0;
						nxt_addr = step[22:0];
						nxt_linear = linear_ff | step[23];
					end
				end
				dpb_pkg::DPB_REGW: begin
					if (rise) begin
						nxt_hi = dq_s;
						nxt_phase = 1'b1;
					end else if (fall && phase_ff) begin
						nxt_reg_wr = 1'b1;
						nxt_reg_wr_data = {hi_ff, dq_s};
						nxt_state = dpb_pkg::DPB_DONE;
					end
				end
				dpb_pkg::DPB_DONE: begin
					nxt_state = dpb_pkg::DPB_DONE;
				end
				default: begin
					nxt_state = dpb_pkg::DPB_DONE;
				end
			endcase
			// arriving read data beats the consume in the same cycle
			if (mem_rd_valid && !is_reg_ff) begin
				nxt_rd_word = mem_rd_data;
				nxt_rd_have = 1'b1;
			end
			if (push && !fifo_in_ready) begin
				nxt_overrun = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= dpb_pkg::DPB_IDLE;
			byte_cnt_ff <= 3'h0;
			ca_ff <= 48'h000000000000;
			lat_cnt_ff <= 5'h00;
			addr_ff <= 23'h000000;
			start_ff <= 23'h000000;
			linear_ff <= 1'b0;
			is_rd_ff <= 1'b0;
			is_reg_ff <= 1'b0;
			phase_ff <= 1'b0;
			mask_hi_ff <= 1'b0;
			hi_ff <= `DPB_BYTE_RST;
			rd_word_ff <= `DPB_WORD_RST;
			rd_have_ff <= 1'b0;
			dq_out_ff <= `DPB_BYTE_RST;
			dq_oe_ff <= 1'b0;
			sm_out_ff <= 1'b0;
			sm_oe_ff <= 1'b0;
			rd_req_ff <= 1'b0;
			reg_wr_ff <= 1'b0;
			reg_wr_data_ff <= `DPB_WORD_RST;
			reg_addr_ff <= `DPB_BYTE_RST;
			overrun_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			byte_cnt_ff <= nxt_byte_cnt;
			ca_ff <= nxt_ca;
			lat_cnt_ff <= nxt_lat_cnt;
			addr_ff <= nxt_addr;
			start_ff <= nxt_start;
			linear_ff <= nxt_linear;
			is_rd_ff <= nxt_is_rd;
			is_reg_ff <= nxt_is_reg;
			phase_ff <= nxt_phase;
			mask_hi_ff <= nxt_mask_hi;
			hi_ff <= nxt_hi;
			rd_word_ff <= nxt_rd_word;
			rd_have_ff <= nxt_rd_have;
			dq_out_ff <= nxt_dq_out;
			dq_oe_ff <= nxt_dq_oe;
			sm_out_ff <= nxt_sm_out;
			sm_oe_ff <= nxt_sm_oe;
			rd_req_ff <= nxt_rd_req;
			reg_wr_ff <= nxt_reg_wr;
			reg_wr_data_ff <= nxt_reg_wr_data;
			reg_addr_ff <= nxt_reg_addr;
			overrun_ff <= nxt_overrun;
		end
	end

	dpb_fifo #(
		.WIDTH(`DPB_WR_W),
		.DEPTH(`DPB_FIFO_DEPTH)
	) u_wr_fifo (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_data),
		.out_valid(mem_wr_valid),
		.out_ready(mem_wr_ready),
		.out_data({mem_wr_addr, mem_wr_data, mem_wr_be})
	);

	assign dq_out = dq_out_ff;
	assign dq_oe = dq_oe_ff;
	assign strobe_mask_out = sm_out_ff;
	assign strobe_mask_oe = sm_oe_ff;
	assign mem_rd_req = rd_req_ff;
	assign mem_rd_addr = addr_ff;
	assign reg_addr = reg_addr_ff;
	assign reg_wr = reg_wr_ff;
	assign reg_wr_data = reg_wr_data_ff;
	assign wr_overrun = overrun_ff;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_ca_end;
		state_ff == dpb_pkg::DPB_CA && (rise || fall)
			&& byte_cnt_ff == `DPB_CA_LAST_BYTE;
	endsequence
	sequence s_rd_hi;
		state_ff == dpb_pkg::DPB_RDATA && rise && rd_have_ff && !cs_s;
	endsequence

	property p_ca_strobe;
		state_ff == dpb_pkg::DPB_CA |-> sm_oe_ff && sm_out_ff;
	endproperty
	a_ca_strobe: assert property (p_ca_strobe)
		else $error("strobe not high during command phase");
	property p_read_dir;
		s_ca_end ##0 (ca_full[47] && !cs_s)
			|=> state_ff != dpb_pkg::DPB_WDATA && is_rd_ff;
	endproperty
	a_read_dir: assert property (p_read_dir)
		else $error("read command not taken as read");
	property p_reg_write;
		s_ca_end ##0 (!ca_full[47] && ca_full[46] && !cs_s)
			|=> state_ff == dpb_pkg::DPB_REGW && !sm_oe_ff;
	endproperty
	a_reg_write: assert property (p_reg_write)
		else $error("register write not zero latency");
	property p_write_quiet;
		state_ff == dpb_pkg::DPB_WDATA |-> !dq_oe_ff && !sm_oe_ff;
	endproperty
	a_write_quiet: assert property (p_write_quiet)
		else $error("device drives pins during write data");
	property p_upper_byte;
		s_rd_hi |=> sm_out_ff && dq_oe_ff
			&& dq_out_ff == $past(rd_word_ff[15:8]);
	endproperty
	a_upper_byte: assert property (p_upper_byte)
		else $error("upper byte not on strobe high half");
	property p_mask;
		push |-> push_data[1:0] == {~mask_hi_ff, ~sm_s};
	endproperty
	a_mask: assert property (p_mask)
		else $error("byte enables disagree with mask");
	property p_deselect;
		cs_s |=> state_ff == dpb_pkg::DPB_IDLE && !dq_oe_ff && !sm_oe_ff;
	endproperty
	a_deselect: assert property (p_deselect)
		else $error("pins not freed after deselect");
	// latency counter stays below the total until it leaves on the total
	property p_latency;
		state_ff == dpb_pkg::DPB_LAT && !cs_s
			|=> (state_ff == dpb_pkg::DPB_LAT && lat_cnt_ff < lat_total)
			|| lat_cnt_ff == lat_total;
	endproperty
	a_latency: assert property (p_latency)
		else $error("latency not twice configured count");
	property p_linear_roll;
		push && linear_ff && addr_ff == 23'h7fffff
			|=> addr_ff == 23'h000000;
	endproperty
	a_linear_roll: assert property (p_linear_roll)
		else $error("linear write did not roll over");

endmodule : dpb_burst

// ---- bench/dpb_master.sv ----
// bus master model: link clock, chip select, data and strobe mask
// assumes ref_clk pacing; link half period is four ref_clk cycles
`timescale 1ns/1ps
module dpb_master (
	input wire logic ref_clk,
	input wire logic [7:0] dq_out,
	input wire logic strobe_mask_out,
	input wire logic strobe_mask_oe,
	output logic link_clk,
	output logic chip_sel_b,
	output logic [7:0] m_dq,
	output logic m_dq_oe,
	output logic m_sm,
	output logic m_sm_oe
);
	logic [7:0] rd_q[$];
	logic cap_en;
	logic last_s;
	logic ca_ok;
	int rises;
	int first_rise;
	initial begin
		link_clk = 1'b0;
		chip_sel_b = 1'b1;
		m_dq = 8'h00;
		m_dq_oe = 1'b0;
		m_sm = 1'b0;
		m_sm_oe = 1'b0;
		cap_en = 1'b0;
		last_s = 1'b0;
	end
	// read bytes taken at each strobe transition
	always @(posedge ref_clk) begin
		last_s <= strobe_mask_out;
		if (cap_en && strobe_mask_oe && strobe_mask_out !== last_s) begin
			if (rd_q.size() == 0)
				first_rise = rises;
			rd_q.push_back(dq_out);
		end
	end
	// data set two cycles ahead of the edge, held two after
	task automatic tog(input logic [7:0] d, input logic s, input logic oe);
		m_dq <= d;
		m_sm <= s;
		m_sm_oe <= oe;
		repeat (2) @(posedge ref_clk);
		if (!link_clk)
			rises++;
		link_clk <= ~link_clk;
		repeat (2) @(posedge ref_clk);
	endtask : tog
	task automatic start(input logic [47:0] c);
		@(posedge ref_clk);
		chip_sel_b <= 1'b0;
		m_dq_oe <= 1'b1;
		repeat (8) @(posedge ref_clk);
		ca_ok = 1'b1;
		rises = 0;
		for (int i = 5; i >= 0; i--) begin
			ca_ok &= strobe_mask_oe & strobe_mask_out;
			tog(c[i*8+:8], 1'b0, 1'b0);
		end
		rises = 0;
	endtask : start
	// mask preamble driven low after the turnaround toggle
	task automatic lat_w(input int t);
		tog(8'h00, 1'b0, 1'b0);
		for (int i = 1; i < t; i++)
			tog(8'h00, 1'b0, 1'b1);
	endtask : lat_w
	task automatic wr(input logic [15:0] d, input logic [1:0] m,
		input logic oe);
		tog(d[15:8], m[1], oe);
		tog(d[7:0], m[0], oe);
	endtask : wr
	task automatic rd(input int n, input int lim);
		m_dq_oe <= 1'b0;
		rd_q.delete();
		first_rise = -1;
		tog(8'h00, 1'b0, 1'b0);
		cap_en = 1'b1;
		for (int i = 1; i < lim && rd_q.size() < 2 * n; i++)
			tog(8'h00, 1'b0, 1'b0);
	endtask : rd
	task automatic stop();
		cap_en = 1'b0;
		if (link_clk)
			tog(8'h00, 1'b0, 1'b0);
		@(posedge ref_clk);
		chip_sel_b <= 1'b1;
		m_dq_oe <= 1'b0;
		m_sm_oe <= 1'b0;
		repeat (16) @(posedge ref_clk);
	endtask : stop
endmodule : dpb_master

// ---- bench/tb_ddr_psram_burst_transactions.sv ----
// testbench for the ddr psram burst transaction block
// assumes the master model; array and register sides modelled here
`timescale 1ns/1ps
module tb_ddr_psram_burst_transactions;
	logic ref_clk, rst_b, junk, link_clk, chip_sel_b, m_dq_oe, m_sm, m_sm_oe;
	logic [7:0] m_dq, dq_out, dq_in, reg_addr;
	logic dq_oe, strobe_mask_out, strobe_mask_oe, strobe_mask_in;
	logic [3:0] latency_count;
	logic [1:0] wrap_code, mem_wr_be, rd_pipe;
	logic hybrid_wrap, mem_rd_req, mem_rd_valid, mem_wr_valid, mem_wr_ready;
	logic [22:0] mem_rd_addr, mem_wr_addr, pend;
	logic [15:0] mem_rd_data, mem_wr_data, reg_rd_data, reg_wr_data;
	logic reg_wr, wr_overrun;
	logic [40:0] wq[$];
	logic [22:0] aq[$];
	logic [23:0] rq[$];
	int bad_count, n_checks;
	assign dq_in = m_dq_oe ? m_dq : (dq_oe ? dq_out : {8{junk}});
	assign strobe_mask_in = m_sm_oe ? m_sm :
		(strobe_mask_oe ? strobe_mask_out : junk);
	dpb_burst i_dut (.ref_clk, .rst_b, .link_clk, .chip_sel_b, .dq_in,
		.dq_out, .dq_oe, .strobe_mask_in, .strobe_mask_out, .strobe_mask_oe,
		.latency_count, .wrap_code, .hybrid_wrap, .mem_rd_req, .mem_rd_addr,
		.mem_rd_valid, .mem_rd_data, .mem_wr_valid, .mem_wr_ready,
		.mem_wr_addr, .mem_wr_data, .mem_wr_be, .reg_addr, .reg_rd_data,
		.reg_wr, .reg_wr_data, .wr_overrun);
	dpb_master i_master (.ref_clk, .dq_out, .strobe_mask_out,
		.strobe_mask_oe, .link_clk, .chip_sel_b, .m_dq, .m_dq_oe, .m_sm,
		.m_sm_oe);
	always #12.5 ref_clk = ~ref_clk;
	function automatic logic [15:0] wf(input logic [22:0] a);
		return {a[7:0] ^ 8'h3c, a[7:0]};
	endfunction : wf
	function automatic logic [47:0] mk(input logic rw, sp, lin,
		input logic [22:0] a);
		return {rw, sp, lin, 9'h000, a[22:3], 13'h0000, a[2:0]};
	endfunction : mk
	// array and register sides
	always @(posedge ref_clk) begin
		junk <= ~junk;
		rd_pipe <= {rd_pipe[0], mem_rd_req};
		mem_rd_valid <= rd_pipe[1];
		mem_rd_data <= wf(pend);
		if (mem_rd_req) begin
			pend <= mem_rd_addr;
			aq.push_back(mem_rd_addr);
		end
		if (mem_wr_valid && mem_wr_ready)
			wq.push_back({mem_wr_addr, mem_wr_data, mem_wr_be});
		if (reg_wr)
			rq.push_back({reg_addr, reg_wr_data});
	end
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic do_read(input logic [47:0] c, input int n);
		aq.delete();
		i_master.start(c);
		i_master.rd(n, 4 * latency_count + 2 * n + 8);
		i_master.stop();
	endtask : do_read
	task automatic do_wr(input logic [47:0] c);
		wq.delete();
		i_master.start(c);
		i_master.lat_w(4 * latency_count);
	endtask : do_wr
	task automatic t_rd_lin();
		logic [22:0] a;
		a = 23'h0001fe;
		latency_count <= 4'h2;
		do_read(mk(1'b1, 1'b0, 1'b1, a), 4);
		check({dq_oe, strobe_mask_oe}, 2'b00);
		check(i_master.ca_ok, 1'b1);
		check(i_master.first_rise, 5);
		for (int i = 0; i < 4; i++) begin
			check(aq[i], a + 23'(i));
			check({i_master.rd_q[2*i], i_master.rd_q[2*i+1]},
				wf(a + 23'(i)));
		end
		$display("t_rd_lin done");
	endtask : t_rd_lin
	task automatic t_rd_wrap();
		logic [22:0] a;
		logic [22:0] e;
		a = 23'h00020e;
		latency_count <= 4'h1;
		wrap_code <= 2'h1;
		hybrid_wrap <= 1'b0;
		do_read(mk(1'b1, 1'b0, 1'b0, a), 4);
		check(i_master.first_rise, 3);
		for (int i = 0; i < 4; i++) begin
			e = {a[22:4], 4'(14 + i)};
			check(aq[i], e);
			check({i_master.rd_q[2*i], i_master.rd_q[2*i+1]}, wf(e));
		end
		$display("t_rd_wrap done");
	endtask : t_rd_wrap
	task automatic t_rd_reg();
		do_read(mk(1'b1, 1'b1, 1'b1, 23'h000000), 2);
		check(aq.size(), 0);
		check({i_master.rd_q[0], i_master.rd_q[1]}, reg_rd_data);
		check({i_master.rd_q[2], i_master.rd_q[3]}, reg_rd_data);
		$display("t_rd_reg done");
	endtask : t_rd_reg
	task automatic t_wr_mask();
		logic [15:0] d[3];
		logic [1:0] m[3];
		logic [22:0] a;
		d = '{16'h1122, 16'h3344, 16'h5566};
		m = '{2'b10, 2'b00, 2'b01};
		a = 23'h000100;
		do_wr(mk(1'b0, 1'b0, 1'b1, a));
		check(strobe_mask_oe, 1'b0);
		check(dq_oe, 1'b0);
		for (int i = 0; i < 3; i++)
			i_master.wr(d[i], m[i], 1'b1);
		i_master.stop();
		for (int i = 0; i < 3; i++)
			check(wq[i], {a + 23'(i), d[i], ~m[i]});
		check(wr_overrun, 1'b0);
		$display("t_wr_mask done");
	endtask : t_wr_mask
	task automatic t_wr_full();
		logic [22:0] a;
		a = 23'h000440;
		mem_wr_ready <= 1'b0;
		do_wr(mk(1'b0, 1'b0, 1'b1, a));
		for (int i = 0; i < 5; i++)
			i_master.wr(16'(16'h0f00 + i), 2'b00, 1'b1);
		i_master.stop();
		check(wr_overrun, 1'b1);
		check(wq.size(), 0);
		mem_wr_ready <= 1'b1;
		repeat (12) @(posedge ref_clk);
		check(wq.size(), 4);
		for (int i = 0; i < 4; i++)
			check(wq[i], {a + 23'(i), 16'(16'h0f00 + i), 2'b11});
		$display("t_wr_full done");
	endtask : t_wr_full
	task automatic t_wr_wrap();
		logic [22:0] a;
		logic [22:0] e;
		a = 23'h000036;
		for (int h = 0; h < 2; h++) begin
			wrap_code <= 2'h0;
			hybrid_wrap <= h[0];
			do_wr(mk(1'b0, 1'b0, 1'b0, a));
			for (int i = 0; i < 10; i++)
				i_master.wr(16'(16'ha000 + i), 2'b00, 1'b1);
			i_master.stop();
			for (int i = 0; i < 10; i++) begin
				e = {a[22:3], 3'(6 + i)};
				if (h == 1 && i >= 8)
					e = a + 23'(i - 6);
				check(wq[i], {e, 16'(16'ha000 + i), 2'b11});
			end
		end
		$display("t_wr_wrap done");
	endtask : t_wr_wrap
	task automatic t_wr_roll();
		logic [22:0] a;
		a = 23'h7ffffe;
		do_wr(mk(1'b0, 1'b0, 1'b1, a));
		for (int i = 0; i < 3; i++)
			i_master.wr(16'(16'h5a00 + i), 2'b00, 1'b1);
		i_master.stop();
		for (int i = 0; i < 3; i++)
			check(wq[i], {a + 23'(i), 16'(16'h5a00 + i), 2'b11});
		$display("t_wr_roll done");
	endtask : t_wr_roll
	task automatic t_reg_wr();
		rq.delete();
		wq.delete();
		i_master.start(mk(1'b0, 1'b1, 1'b1, 23'h000001));
		// last command edge needs sync and detect before the release shows
		repeat (2) @(posedge ref_clk);
		check(strobe_mask_oe, 1'b0);
		i_master.wr(16'h8f1e, 2'b11, 1'b0);
		i_master.stop();
		check(rq.size(), 1);
		check(rq[0], {8'h01, 16'h8f1e});
		check(wq.size(), 0);
		$display("t_reg_wr done");
	endtask : t_reg_wr
	initial begin
		#1000000;
		bad_count++;
		end_of_test();
	end
	initial begin
		ref_clk = 1'b0;
		junk = 1'b0;
		rst_b = 1'b0;
		latency_count = 4'h1;
		wrap_code = 2'h0;
		hybrid_wrap = 1'b0;
		mem_rd_valid = 1'b0;
		mem_rd_data = 16'h0000;
		mem_wr_ready = 1'b1;
		reg_rd_data = 16'hc3a5;
		rd_pipe = 2'b00;
		pend = 23'h000000;
		bad_count = 0;
		n_checks = 0;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_rd_lin();
		t_rd_wrap();
		t_rd_reg();
		t_wr_mask();
		t_wr_full();
		t_wr_wrap();
		t_wr_roll();
		t_reg_wr();
		end_of_test();
	end
endmodule : tb_ddr_psram_burst_transactions
